// ===== include/nrps_pkg.sv
// Package of commands, op codes, pin timing and address layout for the NAND host sequencer
package nrps_pkg;

    // Device command bytes
    localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
    localparam logic [7:0] CMD_READ_START  = 8'h30;
    localparam logic [7:0] CMD_CACHE_NEXT  = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST  = 8'h3F;
    localparam logic [7:0] CMD_COL_RD      = 8'h05;
    localparam logic [7:0] CMD_COL_RD_GO   = 8'hE0;
    localparam logic [7:0] CMD_MREAD_ADDR  = 8'h60;
    localparam logic [7:0] CMD_DATA_IN     = 8'h80;
    localparam logic [7:0] CMD_DATA_IN_2ND = 8'h81;
    localparam logic [7:0] CMD_COL_WR      = 8'h85;
    localparam logic [7:0] CMD_PROG_GO     = 8'h10;
    localparam logic [7:0] CMD_PROG_MID    = 8'h11;
    localparam logic [7:0] CMD_PROG_CACHE  = 8'h15;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_RESET       = 8'hFF;

    // User op codes
    typedef enum logic [3:0] {
        OP_READ_PAGE  = 4'h0, OP_READ_CACHE = 4'h1, OP_READ_LAST = 4'h2, OP_COL_READ  = 4'h3,
        OP_MREAD_ADDR = 4'h4, OP_MREAD_GO   = 4'h5, OP_PROG_LOAD = 4'h6, OP_PROG_LOAD2 = 4'h7,
        OP_COL_PROG   = 4'h8, OP_PROG_GO    = 4'h9, OP_PROG_CACHE = 4'hA, OP_PROG_MID  = 4'hB,
        OP_STATUS     = 4'hC, OP_RESET      = 4'hD
    } nrps_op_e;

    // Data phase direction
    typedef enum logic [1:0] { DIR_NONE = 2'h0, DIR_WR = 2'h1, DIR_RD = 2'h2 } nrps_dir_e;

    // One op as a short pin sequence
    typedef struct packed {
        logic       has_c1;
        logic [7:0] c1;
        logic       has_addr;
        logic [2:0] a_first;
        logic [2:0] a_last;
        nrps_dir_e  dir;
        logic       has_c2;
        logic [7:0] c2;
        logic       wait_rdy;
    } nrps_desc_s;

    // Address cycle indices
    localparam logic [2:0] ADDR_COL_LO = 3'h0;
    localparam logic [2:0] ADDR_COL_HI = 3'h1;
    localparam logic [2:0] ADDR_ROW_LO = 3'h2;
    localparam logic [2:0] ADDR_ROW_TOP = 3'h4;

    // Row field layout: page in block, then block
    localparam int PAGE_MSB  = 5;
    localparam int BLK_LSB   = 6;
    localparam int ROW_MSB   = 17;

    // Pin timing
    localparam int CLK_NS      = 40;
    localparam int WB_NS       = 100;
    localparam int WB_CYC      = (WB_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] WR_LAST_PH = 2'h1;
    localparam logic [1:0] RD_SAMPLE_PH = 2'h1;
    localparam logic [1:0] RD_LAST_PH = 2'h2;

    // Op table
    function automatic nrps_desc_s nrps_decode(input nrps_op_e op);
        nrps_desc_s d;
        d = '{1'b1, CMD_READ_SETUP, 1'b0, ADDR_COL_LO, ADDR_ROW_TOP, DIR_NONE, 1'b0, CMD_READ_START, 1'b0};
        case (op)
            OP_READ_PAGE: begin
                d.has_addr = 1'b1; d.dir = DIR_RD; d.has_c2 = 1'b1; d.wait_rdy = 1'b1;
            end
            OP_READ_CACHE: begin d.c1 = CMD_CACHE_NEXT; d.dir = DIR_RD; d.wait_rdy = 1'b1; end
            OP_READ_LAST:  begin d.c1 = CMD_CACHE_LAST; d.dir = DIR_RD; d.wait_rdy = 1'b1; end
            OP_COL_READ: begin
                d.c1 = CMD_COL_RD; d.has_addr = 1'b1; d.a_last = ADDR_COL_HI;
                d.has_c2 = 1'b1; d.c2 = CMD_COL_RD_GO; d.dir = DIR_RD;
            end
            OP_MREAD_ADDR: begin d.c1 = CMD_MREAD_ADDR; d.has_addr = 1'b1; d.a_first = ADDR_ROW_LO; end
            OP_MREAD_GO:   begin d.c1 = CMD_READ_START; d.wait_rdy = 1'b1; end
            OP_PROG_LOAD:  begin d.c1 = CMD_DATA_IN; d.has_addr = 1'b1; d.dir = DIR_WR; end
            OP_PROG_LOAD2: begin d.c1 = CMD_DATA_IN_2ND; d.has_addr = 1'b1; d.dir = DIR_WR; end
            OP_COL_PROG: begin
                d.c1 = CMD_COL_WR; d.has_addr = 1'b1; d.a_last = ADDR_COL_HI; d.dir = DIR_WR;
            end
            OP_PROG_GO:    begin d.c1 = CMD_PROG_GO; d.wait_rdy = 1'b1; end
            OP_PROG_CACHE: begin d.c1 = CMD_PROG_CACHE; d.wait_rdy = 1'b1; end
            OP_PROG_MID:   begin d.c1 = CMD_PROG_MID; d.wait_rdy = 1'b1; end
            OP_STATUS:     begin d.c1 = CMD_STATUS; d.dir = DIR_RD; end
            OP_RESET:      begin d.c1 = CMD_RESET; d.wait_rdy = 1'b1; end
            default:       d.has_c1 = 1'b0;
        endcase
        return d;
    endfunction : nrps_decode

endpackage : nrps_pkg

// ===== src/nrps_host.sv
// Host controller that drives the NAND flash pins for read and program sequences
`timescale 1ns/1ps

module nrps_host
    import nrps_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // User op port
    input  wire logic        op_valid,
    output logic             op_ready,
    input  wire logic [3:0]  op_code,
    input  wire logic [12:0] op_col,
    input  wire logic [17:0] op_row,
    input  wire logic [12:0] op_len,
    input  wire logic        protect,
    output logic             op_error,
    output logic             op_done,
    output logic             busy,
    // Write data stream
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [7:0]  wr_data,
    // Read data and status
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    output logic             status_valid,
    output logic [7:0]       status_byte,
    // Flash pins
    output logic             ce_n,
    output logic             cle,
    output logic             ale,
    output logic             we_n,
    output logic             read_strobe_n,
    output logic             wp_n,
    output logic [7:0]       io_out,
    output logic             io_oe,
    input  wire logic [7:0]  io_in,
    input  wire logic        ready_busy_n
);

    // Sequencer states, Gray in declaration order
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_CMD1 = 3'b001, ST_ADDR = 3'b011, ST_DATA = 3'b010,
        ST_CMD2 = 3'b110, ST_WB   = 3'b111, ST_RDY  = 3'b101, ST_DONE = 3'b100
    } nrps_state_e;

    // Ready/busy synchroniser and filtered level
    logic       rb_s1, rb_s2, rb_s3;             // Three stage chain
    logic       rdy;                             // Agreed level
    logic       next_rdy;

    // Sequencer state
    nrps_state_e state, next_state;
    nrps_desc_s  desc, next_desc;                // Op being run
    logic [3:0]  op, next_op;                    // Op code being run
    logic [1:0]  ph, next_ph;                    // Phase inside one pin cycle
    logic [2:0]  aidx, next_aidx;                // Address cycle index
    logic [12:0] cnt, next_cnt;                  // Data bytes left
    logic [12:0] col, next_col;
    logic [17:0] row, next_row;
    logic [12:0] len_q, next_len_q;              // Read length kept across the busy wait

    // Session tracking for ordered sequences
    logic        cr_open, next_cr_open;          // Cached read session
    logic [11:0] cr_blk, next_cr_blk;            // Block of cached read
    logic        mr_first, next_mr_first;        // First district row given
    logic        mr_both, next_mr_both;          // Both district rows given
    logic        mp_mid, next_mp_mid;            // Between 11h and 81h
    logic [17:0] pair_row, next_pair_row;        // Row of the first district
    logic [17:0] last_row, next_last_row;        // Row of the last program load

    // Registered pin and user outputs
    logic        next_cle, next_ale, next_we_n, next_re_n, next_wp_n, next_io_oe;
    logic [7:0]  next_io_out, next_rd_data, next_status_byte;
    logic        next_rd_valid, next_status_valid, next_op_error, next_op_done;

    // Decode and admission helpers
    nrps_desc_s  dec;
    logic        ok;
    logic [7:0]  abyte;
    nrps_op_e    op_in;

    // Pair check: same page bits, same half, other district
    function automatic logic pair_ok(input logic [17:0] a, input logic [17:0] b);
        return (a[PAGE_MSB:0] == b[PAGE_MSB:0])
            && (a[ROW_MSB] == b[ROW_MSB])
            && (a[BLK_LSB] != b[BLK_LSB]);
    endfunction : pair_ok

    // Ready level changes only when the later two stages agree
    always_comb begin
        next_rdy = (rb_s2 == rb_s3) ? rb_s3 : rdy;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rb_s1 <= 1'b0;
            rb_s2 <= 1'b0;
            rb_s3 <= 1'b0;
            rdy   <= 1'b0;
        end else begin
            rb_s1 <= ready_busy_n;
            rb_s2 <= rb_s1;
            rb_s3 <= rb_s2;
            rdy   <= next_rdy;
        end
    end

    // Handshakes are combinational from state
    assign op_ready = (state == ST_IDLE);
    assign wr_ready = (state == ST_DATA) && (desc.dir == DIR_WR) && (ph == 2'h0) && (cnt != 13'h0000);
    assign busy     = (state != ST_IDLE);
    assign ce_n     = 1'b0;                      // Single target, always selected

    // Address byte for the current cycle, column then row
    always_comb begin
        case (aidx)
            3'h0:    abyte = col[7:0];
            3'h1:    abyte = {3'h0, col[12:8]};
            3'h2:    abyte = row[7:0];
            3'h3:    abyte = row[15:8];
            default: abyte = {6'h00, row[17:16]};
        endcase
    end

    // Admission of a new op against the session state
    always_comb begin
        op_in = nrps_op_e'(op_code);
        dec   = nrps_decode(op_in);
        ok    = dec.has_c1;
        // Only status and reset may go to a busy device
        if (!rdy && op_in != OP_STATUS && op_in != OP_RESET) ok = 1'b0;
        // Cached read stays in its opening block
        if ((op_in == OP_READ_CACHE || op_in == OP_READ_LAST)
            && (!cr_open || op_row[ROW_MSB:BLK_LSB] != cr_blk)) ok = 1'b0;
        // Between 11h and 81h only status, reset or the second load
        if (mp_mid && op_in != OP_STATUS && op_in != OP_RESET && op_in != OP_PROG_LOAD2) ok = 1'b0;
        if (op_in == OP_PROG_LOAD2 && (!mp_mid || !pair_ok(pair_row, op_row))) ok = 1'b0;
        if (op_in == OP_MREAD_ADDR && (mr_both || (mr_first && !pair_ok(pair_row, op_row)))) ok = 1'b0;
        if (op_in == OP_MREAD_GO && !mr_both) ok = 1'b0;
    end

    // Sequencer next state
    always_comb begin
        next_state = state;       next_desc = desc;       next_op = op;
        next_ph = ph;             next_aidx = aidx;       next_cnt = cnt;
        next_col = col;           next_row = row;
        next_cr_open = cr_open;   next_cr_blk = cr_blk;
        next_mr_first = mr_first; next_mr_both = mr_both; next_mp_mid = mp_mid;
        next_pair_row = pair_row; next_last_row = last_row;
        next_cle = 1'b0;          next_ale = 1'b0;        next_we_n = 1'b1;
        next_re_n = 1'b1;         next_io_oe = io_oe;     next_io_out = io_out;
        next_rd_data = rd_data;   next_status_byte = status_byte;
        next_rd_valid = 1'b0;     next_status_valid = 1'b0;
        next_op_error = 1'b0;     next_op_done = 1'b0;
        // Protect is lifted for the whole multi read, through the 30h and its busy
        next_wp_n = !protect || mr_first || mr_both || (op == OP_MREAD_GO && state != ST_IDLE);
        case (state)
            ST_IDLE: begin
                next_io_oe = 1'b0;
                next_ph    = 2'h0;
                if (op_valid && !ok) begin
                    next_op_error = 1'b1;
                end else if (op_valid) begin
                    next_desc = dec;
                    next_op   = op_code;
                    next_aidx = dec.a_first;
                    next_cnt  = (op_in == OP_STATUS) ? 13'h0001 : op_len;
                    next_col  = op_col;
                    next_row  = op_row;
                    next_state = ST_CMD1;
                    // Session bookkeeping
                    case (op_in)
                        OP_READ_PAGE: begin next_cr_open = 1'b1; next_cr_blk = op_row[ROW_MSB:BLK_LSB]; end
                        OP_READ_LAST: next_cr_open = 1'b0;
                        OP_MREAD_ADDR: begin
                            if (mr_first) next_mr_both = 1'b1;
                            else begin next_mr_first = 1'b1; next_pair_row = op_row; end
                        end
                        OP_MREAD_GO: begin next_mr_first = 1'b0; next_mr_both = 1'b0; end
                        OP_PROG_LOAD: begin next_last_row = op_row; next_cr_open = 1'b0; end
                        OP_PROG_MID: begin next_mp_mid = 1'b1; next_pair_row = last_row; end
                        OP_PROG_LOAD2: next_mp_mid = 1'b0;
                        OP_RESET: begin
                            next_cr_open = 1'b0; next_mr_first = 1'b0; next_mr_both = 1'b0; next_mp_mid = 1'b0;
                        end
                        default: ;
                    endcase
                end
            end
            // Command byte latched on the rising write strobe
            ST_CMD1, ST_CMD2: begin
                next_io_oe  = 1'b1;
                next_io_out = (state == ST_CMD1) ? desc.c1 : desc.c2;
                next_cle    = 1'b1;
                next_we_n   = (ph != 2'h0);
                next_ph     = ph + 2'h1;
                if (ph == WR_LAST_PH) begin
                    next_ph = 2'h0;
                    if (state == ST_CMD2) next_state = desc.wait_rdy ? ST_WB : ST_DATA;
                    else if (desc.has_addr) next_state = ST_ADDR;
                    else if (desc.wait_rdy) next_state = ST_WB;
                    else next_state = ST_DATA;
                end
            end
            // Address bytes latched while ALE is high
            ST_ADDR: begin
                next_io_oe  = 1'b1;
                next_io_out = abyte;
                next_ale    = 1'b1;
                next_we_n   = (ph != 2'h0);
                next_ph     = ph + 2'h1;
                if (ph == WR_LAST_PH) begin
                    next_ph   = 2'h0;
                    next_aidx = aidx + 3'h1;
                    if (aidx == desc.a_last) begin
                        if (desc.has_c2 && desc.dir != DIR_RD) next_state = ST_CMD2;
                        else if (desc.has_c2) next_state = ST_CMD2;
                        else next_state = ST_DATA;
                    end
                end
            end
            // Data stream; write stalls while no byte is offered
            ST_DATA: begin
                if (cnt == 13'h0000 || desc.dir == DIR_NONE) begin
                    next_io_oe = 1'b0;
                    next_state = ST_DONE;
                end else if (desc.dir == DIR_WR) begin
                    if (ph == 2'h0 && wr_valid) begin
                        next_io_oe  = 1'b1;
                        next_io_out = wr_data;
                        next_we_n   = 1'b0;
                        next_ph     = 2'h1;
                    end else if (ph != 2'h0) begin
                        next_ph  = 2'h0;
                        next_cnt = cnt - 13'h0001;
                    end
                end else begin
                    // Rising read strobe advances the column in the device
                    next_io_oe = 1'b0;
                    next_re_n  = (ph == RD_LAST_PH);
                    next_ph    = ph + 2'h1;
                    if (ph == RD_SAMPLE_PH) begin
                        if (op == OP_STATUS) begin
                            next_status_byte  = io_in;
                            next_status_valid = 1'b1;
                        end else begin
                            next_rd_data  = io_in;
                            next_rd_valid = 1'b1;
                        end
                    end
                    if (ph == RD_LAST_PH) begin
                        next_ph  = 2'h0;
                        next_cnt = cnt - 13'h0001;
                    end
                end
            end
            // Let the device pull busy low before looking at it
            ST_WB: begin
                next_io_oe = 1'b0;
                next_cnt   = (ph == 2'h0) ? 13'(WB_CYC) : cnt - 13'h0001;
                next_ph    = 2'h1;
                if (ph != 2'h0 && cnt == 13'h0001) begin
                    next_ph    = 2'h0;
                    // Only reads have a data phase after the wait
                    next_cnt   = (desc.dir == DIR_RD) ? len_q : 13'h0000;
                    next_state = ST_RDY;
                end
            end
            // Hold off until ready returns; this also covers cache busy
            ST_RDY: begin
                if (rdy) next_state = ST_DATA;
            end
            ST_DONE: begin
                next_op_done = 1'b1;
                next_state   = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Length of the current op, kept across the busy wait
    always_comb begin
        next_len_q = (state == ST_IDLE && op_valid && ok) ? op_len : len_q;
    end

    // Register all sequencer state and pin drives
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;   desc <= '0;       op <= 4'h0;     ph <= 2'h0;
            aidx <= 3'h0;       cnt <= 13'h0000;  col <= 13'h0000; row <= 18'h00000;
            len_q <= 13'h0000;
            cr_open <= 1'b0;    cr_blk <= 12'h000; mr_first <= 1'b0; mr_both <= 1'b0;
            mp_mid <= 1'b0;     pair_row <= 18'h00000; last_row <= 18'h00000;
            cle <= 1'b0;        ale <= 1'b0;      we_n <= 1'b1;   read_strobe_n <= 1'b1;
            wp_n <= 1'b0;       io_oe <= 1'b0;    io_out <= 8'h00;
            rd_data <= 8'h00;   status_byte <= 8'h00;
            rd_valid <= 1'b0;   status_valid <= 1'b0; op_error <= 1'b0; op_done <= 1'b0;
        end else begin
            state <= next_state; desc <= next_desc; op <= next_op; ph <= next_ph;
            aidx <= next_aidx;  cnt <= next_cnt;  col <= next_col; row <= next_row;
            len_q <= next_len_q;
            cr_open <= next_cr_open; cr_blk <= next_cr_blk;
            mr_first <= next_mr_first; mr_both <= next_mr_both;
            mp_mid <= next_mp_mid; pair_row <= next_pair_row; last_row <= next_last_row;
            cle <= next_cle;    ale <= next_ale;  we_n <= next_we_n; read_strobe_n <= next_re_n;
            wp_n <= next_wp_n;  io_oe <= next_io_oe; io_out <= next_io_out;
            rd_data <= next_rd_data; status_byte <= next_status_byte;
            rd_valid <= next_rd_valid; status_valid <= next_status_valid;
            op_error <= next_op_error; op_done <= next_op_done;
        end
    end

endmodule : nrps_host

// ===== dv/nrps_checker.sv
// Checker of the host pin timing and the op port
`timescale 1ns/1ps
module nrps_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Op port
    input wire logic op_ready,
    input wire logic op_error,
    input wire logic op_done,
    input wire logic busy,
    // Flash pins
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic io_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Start of a write strobe, and two low clocks of a read strobe
    sequence s_wr_low; $fell(we_n); endsequence
    sequence s_rd_low; $fell(read_strobe_n) ##1 !read_strobe_n; endsequence
    chk_latch_excl: assert property (!(cle && ale)) else $error("cle and ale high together");
    chk_strobe_excl: assert property (we_n || read_strobe_n) else $error("both strobes low");
    chk_we_pulse: assert property (s_wr_low |=> we_n) else $error("write strobe low too long");
    chk_drive_write: assert property (!we_n |-> io_oe) else $error("io not driven at write");
    chk_read_float: assert property (!read_strobe_n |-> !io_oe) else $error("io driven at read");
    chk_read_phase: assert property (s_rd_low |=> read_strobe_n) else $error("read strobe length");
    chk_strobe_busy: assert property (!(we_n && read_strobe_n) |-> $past(busy)) else $error("strobe no op");
    chk_error_idle: assert property (op_error |-> op_ready && !op_done) else $error("refusal not idle");
    chk_idle_pins: assert property (op_ready && $past(op_ready) |-> we_n && read_strobe_n)
        else $error("strobe while idle");
endmodule : nrps_checker

// ===== dv/nrps_flash_model.sv
// Behavioural NAND device answering the host pins
`timescale 1ns/1ps
module nrps_flash_model (
    // Clock and pins from host
    input wire logic       ref_clk,
    input wire logic       cle,
    input wire logic       ale,
    input wire logic       we_n,
    input wire logic       re_n,
    input wire logic [7:0] io_out,
    input wire logic       fail,
    // Pins to host
    output logic [7:0]     io_in,
    output logic           ready_busy_n
);
    logic [7:0] cmd  = 8'h00; // Read setup presumed at power-up
    logic [7:0] col  = 8'h00; // Column pointer low byte
    logic [2:0] acnt = 3'h0;  // Address cycle count
    logic [7:0] bcnt = 8'h00; // Busy clocks left
    logic       re_q = 1'b1;  // Read strobe at last edge
    int         nwr  = 0;     // Data bytes taken
    // Fail on bit zero, buffer and cache ready on bits five and six
    wire logic [7:0] stat = {1'b0, ready_busy_n, ready_busy_n, 4'h0, fail};
    assign ready_busy_n = (bcnt == 8'h00);
    // Released bus shows the inverse, so a stale byte never passes
    assign io_in = (cmd == 8'h70 ? stat : col) ^ {8{re_n}};
    // Latch at the clock that ends a write strobe low phase
    always @(posedge ref_clk) begin
        re_q <= re_n;
        if (bcnt != 8'h00) bcnt <= bcnt - 8'h01;
        if (re_n && !re_q) col <= col + 8'h01;
        if (!we_n && cle) begin
            cmd  <= io_out;
            acnt <= 3'h0;
            if (io_out inside {8'h31, 8'h3F}) begin // Short busy
                col  <= 8'h00;
                bcnt <= 8'h04;
            end
            if (io_out inside {8'h30, 8'h10, 8'h11, 8'h15, 8'hFF}) begin
                bcnt <= 8'h0C; // Long busy
            end
        end else if (!we_n && ale) begin
            acnt <= acnt + 3'h1;
            if (acnt == 3'h0) col <= io_out;
        end else if (!we_n) nwr <= nwr + 1;
    end
endmodule : nrps_flash_model

// ===== dv/nand_read_program_sequencer_tb_top.sv
// Self-checking bench of the NAND host sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module nand_read_program_sequencer_tb_top;
    import nrps_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, op_valid = 1'b0, protect = 1'b1, wr_valid = 1'b0, fail = 1'b0;
    logic op_ready, op_error, op_done, wr_ready, rd_valid, status_valid, cle, ale, we_n, read_strobe_n;
    logic wp_n, io_oe, ready_busy_n;
    logic [3:0]  op_code = 4'h0;
    logic [12:0] op_col = 13'h0000, op_len = 13'h0000;
    logic [17:0] op_row = 18'h00000;
    logic [7:0]  wr_data = 8'h00, rd_data, status_byte, io_out, io_in, st_q;
    logic [7:0]  rq[$]; // Read bytes seen
    int          errors = 0, num_checks = 0, nw;
    nrps_host i_dut (.ref_clk, .reset, .op_valid, .op_ready, .op_code, .op_col, .op_row, .op_len, .protect,
        .op_error, .op_done, .busy(), .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data, .status_valid,
        .status_byte, .ce_n(), .cle, .ale, .we_n, .read_strobe_n, .wp_n, .io_out, .io_oe, .io_in, .ready_busy_n);
    nrps_flash_model i_mdl (.ref_clk, .cle, .ale, .we_n, .re_n(read_strobe_n), .io_out, .fail, .io_in,
        .ready_busy_n);
    always #20 ref_clk = !ref_clk;
    // Collect outputs; a write offer stands until taken, then the stream rests a clock
    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (status_valid === 1'b1) st_q <= status_byte;
        if (op_code == OP_MREAD_GO && op_ready === 1'b0) `CHK(wp_n, 1'b1)
        if (wr_valid && wr_ready) wr_data <= #1 wr_data + 8'h01;
        if (!wr_valid || wr_ready) wr_valid <= #1 !wr_valid;
    end
    // Present one op, wait for its end, compare the refusal flag
    task automatic op(input logic [3:0] c, input logic [12:0] cl, input logic [17:0] rw, input logic [12:0] ln,
                      input logic e);
        int n;
        n = 0;
        {op_code, op_col, op_row, op_len, op_valid} = {c, cl, rw, ln, 1'b1};
        do @(posedge ref_clk); while (op_ready !== 1'b1);
        #1 op_valid = 1'b0;
        do begin @(posedge ref_clk); n++; end while (op_done !== 1'b1 && op_error !== 1'b1 && n < 3000);
        `CHK(op_done | op_error, 1'b1)
        `CHK(op_error, e)
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : op
    task automatic rd_chk(input logic [7:0] s, input int n);
        logic [7:0] b;
        `CHK(rq.size(), n)
        for (int i = 0; i < n && rq.size() > 0; i++) begin
            b = rq.pop_front();
            `CHK(b, s + 8'(i))
        end
        rq = {};
    endtask : rd_chk
    task automatic tend(input string s);
        $display("Test %s done", s);
    endtask : tend
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    // Main sequence of tests
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 reset = 1'b0;
        op(OP_STATUS, 0, 0, 0, 1'b0);
        `CHK(st_q, 8'h60)
        op(OP_READ_CACHE, 0, 18'h00041, 2, 1'b1);
        op(OP_READ_PAGE, 13'h0005, 18'h00041, 3, 1'b0);
        rd_chk(8'h05, 3);
        op(OP_COL_READ, 13'h00FE, 0, 3, 1'b0);
        rd_chk(8'hFE, 3);
        op(OP_READ_CACHE, 0, 18'h00042, 2, 1'b0);
        rd_chk(8'h00, 2);
        op(OP_READ_CACHE, 0, 18'h00081, 2, 1'b1);
        op(OP_READ_LAST, 0, 18'h00043, 2, 1'b0);
        rd_chk(8'h00, 2);
        op(OP_READ_CACHE, 0, 18'h00044, 2, 1'b1);
        tend("read");
        nw = i_mdl.nwr;
        op(OP_PROG_LOAD, 13'h0010, 18'h00041, 4, 1'b0);
        op(OP_COL_PROG, 13'h0020, 0, 2, 1'b0);
        op(OP_PROG_GO, 0, 0, 0, 1'b0);
        `CHK(i_mdl.nwr - nw, 6)
        fail = 1'b1;
        op(OP_STATUS, 0, 0, 0, 1'b0);
        `CHK(st_q, 8'h61)
        fail = 1'b0;
        tend("program");
        op(OP_MREAD_ADDR, 0, 18'h00041, 0, 1'b0);
        `CHK(wp_n, 1'b1)
        op(OP_MREAD_ADDR, 0, 18'h000C1, 0, 1'b1);
        op(OP_MREAD_ADDR, 0, 18'h20081, 0, 1'b1);
        op(OP_MREAD_GO, 0, 0, 0, 1'b1);
        op(OP_MREAD_ADDR, 0, 18'h00081, 0, 1'b0);
        op(OP_MREAD_GO, 0, 0, 0, 1'b0);
        tend("multi read");
        op(OP_PROG_LOAD, 13'h0000, 18'h00041, 2, 1'b0);
        op(OP_PROG_MID, 0, 0, 0, 1'b0);
        op(OP_READ_PAGE, 0, 18'h00041, 1, 1'b1);
        op(OP_PROG_LOAD2, 13'h0000, 18'h00081, 2, 1'b0);
        op(OP_PROG_CACHE, 0, 0, 0, 1'b0);
        op(OP_PROG_LOAD, 13'h0000, 18'h00042, 2, 1'b0);
        op(OP_PROG_CACHE, 0, 0, 0, 1'b0);
        op(OP_PROG_LOAD, 13'h0000, 18'h00043, 2, 1'b0);
        op(OP_PROG_GO, 0, 0, 0, 1'b0);
        op(4'hE, 0, 0, 0, 1'b1);
        op(OP_RESET, 0, 0, 0, 1'b0);
        tend("cache program");
        summarize;
    end
    // Watchdog well beyond the expected run
    initial begin
        #(40 * 40000);
        errors++;
        summarize;
    end
endmodule : nand_read_program_sequencer_tb_top
bind nrps_host nrps_checker i_chk (.ref_clk, .reset, .op_ready, .op_error, .op_done, .busy, .cle, .ale, .we_n,
    .read_strobe_n, .io_oe);
